/* hdl/stepper_disable_pkg.sv */
// shared constants and types for the stepper output-disable block
package stepper_disable_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IRQ_STATUS_OFFSET = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFFSET = 8'h0C;
    localparam logic [7:0] PHASE_OFFSET = 8'h10;
    // ctrl fields
    localparam int CTRL_FAULT_CLR_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status fields
    localparam int ST_OUT_EN_BIT = 0;
    localparam int ST_REF_DIS_BIT = 1;
    localparam int ST_HOLD_SLEEP_BIT = 2;
    localparam int ST_FAULT_BIT = 3;
    localparam int ST_WAKE_OK_BIT = 4;
    // interrupt event bits
    localparam int EV_DISABLE_BIT = 0;
    localparam int EV_ENABLE_BIT = 1;
    localparam int EV_FAULT_BIT = 2;
    localparam int EV_EARLY_STEP_BIT = 3;
    localparam int EV_WIDTH = 4;
    localparam logic [EV_WIDTH-1:0] IRQ_MASK_RESET = 4'h0;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int WAKE_DELAY_US = 100;
    localparam int WAKE_DELAY_CYCLES = WAKE_DELAY_US * CLK_MHZ;
    // home excitation index
    localparam logic [2:0] HOME_PHASE = 3'h0;

    typedef struct packed {
        logic step_clock;
        logic rotation_direction_select;
        logic step_mode_select_0;
        logic step_mode_select_1;
        logic reset_request;
        logic reference_disable_input;
        logic hold_sleep_input;
        logic fault_detect;
    } pins_t;
endpackage

/* hdl/stepper_output_disable_control.sv */
// output-disable control, step sequencer and apb registers for a stepper driver
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module stepper_output_disable_control
    import stepper_disable_pkg::*;
#(
    parameter int WAKE_CYCLES = WAKE_DELAY_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pins_t pins,
    output logic [3:0] phase_drive,
    output logic sleep_state,
    output logic home_monitor_o,
    output logic home_monitor_oe_n,
    output logic fault_flag_o,
    output logic fault_flag_oe_n,
    output logic irq
);
    // a zero wake delay would leave the early-step event meaningless
    if (WAKE_CYCLES < 1) begin : g_bad_wake
        $error("WAKE_CYCLES must be at least 1");
    end

    pins_t sync1_q, sync2_q;
    logic step_prev_q, hold_prev_q;
    logic [2:0] phase_q;
    logic fault_q;
    logic [31:0] wake_cnt_q;
    logic [EV_WIDTH-1:0] irq_status_q, irq_mask_q;
    logic out_dis_prev_q;

    wire logic ref_dis = sync2_q.reference_disable_input;
    wire logic hold_sleep = sync2_q.hold_sleep_input;
    wire logic out_dis = ref_dis | hold_sleep;
    wire logic step_rise = sync2_q.step_clock & ~step_prev_q;
    wire logic wake_ok = (wake_cnt_q == 32'h0000_0000);
    wire logic apb_wr = psel & penable & pwrite;
    wire logic fault_clr_wr = apb_wr && paddr == CTRL_OFFSET && pwdata[CTRL_FAULT_CLR_BIT];

    // phase step for the selected mode: full (two) or half (one) increments
    function automatic logic [2:0] next_phase(input logic [2:0] p, input logic dir,
                                              input logic m0, input logic m1);
        logic [2:0] inc;
        inc = (m0 | m1) ? 3'h1 : 3'h2;
        return dir ? p - inc : p + inc;
    endfunction

    function automatic logic [3:0] excitation(input logic [2:0] p);
        logic [3:0] e;
        unique case (p)
            3'h0: e = 4'h9;
            3'h1: e = 4'h1;
            3'h2: e = 4'h3;
            3'h3: e = 4'h2;
            3'h4: e = 4'h6;
            3'h5: e = 4'h4;
            3'h6: e = 4'hC;
            default: e = 4'h8;
        endcase
        return e;
    endfunction

    // pins come from another domain: two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            step_prev_q <= 1'b0;
            hold_prev_q <= 1'b0;
            out_dis_prev_q <= 1'b0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            step_prev_q <= sync2_q.step_clock;
            hold_prev_q <= hold_sleep;
            out_dis_prev_q <= out_dis;
        end
    end

    // sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_q <= HOME_PHASE;
        end else if (sync2_q.reset_request) begin
            phase_q <= HOME_PHASE;
        end else if (step_rise && !hold_sleep) begin
            phase_q <= next_phase(phase_q, sync2_q.rotation_direction_select,
                                  sync2_q.step_mode_select_0, sync2_q.step_mode_select_1);
        end
    end

    // protection latch; detection wins over software clear, hold sleep clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q <= 1'b0;
        end else if (sync2_q.fault_detect) begin
            fault_q <= 1'b1;
        end else if ((hold_sleep && !hold_prev_q) || fault_clr_wr) begin
            fault_q <= 1'b0;
        end
    end

    // wake delay tracking so software can see when stepping is safe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_q <= 32'h0000_0000;
        end else if (out_dis) begin
            wake_cnt_q <= 32'(WAKE_CYCLES);
        end else if (!wake_ok) begin
            wake_cnt_q <= wake_cnt_q - 32'h0000_0001;
        end
    end

    // outputs; drives gated off in either sleep so the motor coasts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_drive <= 4'h0;
            sleep_state <= 1'b0;
            home_monitor_o <= 1'b0;
            home_monitor_oe_n <= 1'b1;
            fault_flag_o <= 1'b0;
            fault_flag_oe_n <= 1'b1;
        end else begin
            phase_drive <= out_dis ? 4'h0 : excitation(phase_q);
            sleep_state <= out_dis;
            home_monitor_o <= 1'b0;
            home_monitor_oe_n <= !(phase_q == HOME_PHASE);
            fault_flag_o <= 1'b0;
            fault_flag_oe_n <= !fault_q;
        end
    end

    // interrupt status: set wins over write-one-to-clear
    logic [EV_WIDTH-1:0] ev;
    always_comb begin
        ev = '0;
        ev[EV_DISABLE_BIT] = out_dis && !out_dis_prev_q;
        ev[EV_ENABLE_BIT] = !out_dis && out_dis_prev_q;
        ev[EV_FAULT_BIT] = sync2_q.fault_detect && !fault_q;
        ev[EV_EARLY_STEP_BIT] = step_rise && !out_dis && !wake_ok;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= (irq_status_q &
                             ~((apb_wr && paddr == IRQ_STATUS_OFFSET) ?
                               pwdata[EV_WIDTH-1:0] : '0)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= IRQ_MASK_RESET;
        end else if (apb_wr && paddr == IRQ_MASK_OFFSET) begin
            irq_mask_q <= pwdata[EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status_q & irq_mask_q);
        end
    end

    // apb slave: no wait states, reads registered in setup
    logic [31:0] rd;
    logic known;
    always_comb begin
        rd = 32'h0000_0000;
        known = 1'b1;
        unique case (paddr)
            CTRL_OFFSET: rd = CTRL_RESET;
            STATUS_OFFSET: begin
                rd[ST_OUT_EN_BIT] = !out_dis;
                rd[ST_REF_DIS_BIT] = ref_dis;
                rd[ST_HOLD_SLEEP_BIT] = hold_sleep;
                rd[ST_FAULT_BIT] = fault_q;
                rd[ST_WAKE_OK_BIT] = wake_ok;
            end
            IRQ_STATUS_OFFSET: rd[EV_WIDTH-1:0] = irq_status_q;
            IRQ_MASK_OFFSET: rd[EV_WIDTH-1:0] = irq_mask_q;
            PHASE_OFFSET: rd[2:0] = phase_q;
            default: known = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !known;
            prdata <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

/* dv/stepper_disable_properties.sv */
// concurrent checks on the stepper output-disable block ports
`timescale 1ns/1ps
`default_nettype none
module stepper_disable_properties
    import stepper_disable_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire pins_t pins,
    input wire logic [3:0] phase_drive,
    input wire logic sleep_state,
    input wire logic home_monitor_o,
    input wire logic home_monitor_oe_n,
    input wire logic fault_flag_o,
    input wire logic fault_flag_oe_n
);
    wire r = pins.reference_disable_input;
    wire h = pins.hold_sleep_input;
    wire f = pins.fault_detect;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_coast; sleep_state |-> phase_drive == 4'h0; endproperty
    a_coast: assert property (p_coast) else $error("drive in sleep");
    property p_ref; r [*4] |=> sleep_state; endproperty
    a_ref: assert property (p_ref) else $error("ref gives no sleep");
    property p_hold; h [*4] |=> sleep_state; endproperty
    a_hold: assert property (p_hold) else $error("hold gives no sleep");
    property p_on; (!r && !h) [*5] |=> !sleep_state; endproperty
    a_on: assert property (p_on) else $error("no wake");
    // reset request may still move the phase, so it is excluded
    property p_freeze; (h && !pins.reset_request) [*6] |=> $stable(home_monitor_oe_n); endproperty
    a_freeze: assert property (p_freeze) else $error("phase moved in hold");
    property p_od; home_monitor_o == 1'b0 && fault_flag_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("open drain drives high");
    property p_home; pins.reset_request [*5] |=> !home_monitor_oe_n; endproperty
    a_home: assert property (p_home) else $error("not home");
    property p_clr; !f [*4] ##0 $rose(h) ##1 !f [*4] |=> fault_flag_oe_n; endproperty
    a_clr: assert property (p_clr) else $error("fault not cleared");
    c_ref: cover property (r [*4] ##1 sleep_state);
    c_clr: cover property ($rose(h) ##6 fault_flag_oe_n);
    c_step: cover property ($changed(home_monitor_oe_n));
endmodule
`default_nettype wire

/* dv/step_controller_model.sv */
// controller model driving the stepper logic pins
`timescale 1ns/1ps
`default_nettype none
module step_controller_model
    import stepper_disable_pkg::*;
#(
    parameter int WAKE = 20
) (
    input wire logic pclk,
    output var pins_t pins
);
    initial pins = '0;
    task automatic hold(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // high and low phases kept well above the two-clock minimum
    task automatic step(input logic d, input logic [1:0] m);
        pins.rotation_direction_select <= d;
        {pins.step_mode_select_1, pins.step_mode_select_0} <= m;
        pins.step_clock <= 1'b1;
        hold(3);
        pins.step_clock <= 1'b0;
        hold(6);
    endtask
    task automatic disables(input logic r, input logic h);
        pins.reference_disable_input <= r;
        pins.hold_sleep_input <= h;
        hold((r | h) ? 8 : WAKE + 8);
    endtask
    // breaks the wake delay on purpose to provoke the early-step event
    task automatic early(input logic d, input logic [1:0] m);
        pins.reference_disable_input <= 1'b1;
        hold(8);
        pins.reference_disable_input <= 1'b0;
        hold(2);
        step(d, m);
    endtask
    task automatic pulse(input int b);
        pins[b] <= 1'b1;
        hold(4);
        pins[b] <= 1'b0;
        hold(8);
    endtask
endmodule
`default_nettype wire

/* dv/stepper_output_disable_control_test.sv */
// self-checking bench for the stepper output-disable block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("wrong value at %0t got %h exp %h", $time, a, b); end end
module stepper_output_disable_control_test
    import stepper_disable_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, v, seed = 32'h3AD171D1;
    logic pready, pslverr, sleep_state, irq, hm, hoe, fo, foe;
    logic [3:0] phase_drive;
    logic [2:0] ph = 3'h0;
    pins_t pins;
    int err_count = 0, checked = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    step_controller_model #(.WAKE(20)) ctl (.pclk, .pins);
    stepper_output_disable_control #(.WAKE_CYCLES(20)) uut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pins,
        .phase_drive, .sleep_state, .home_monitor_o(hm), .home_monitor_oe_n(hoe),
        .fault_flag_o(fo), .fault_flag_oe_n(foe), .irq);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [3:0] exc(input logic [2:0] p);
        logic [31:0] t;
        t = 32'h8C462319;
        return t[p * 4 +: 4];
    endfunction
    function automatic logic [2:0] nxt(input logic [2:0] p, input logic d, input logic [1:0] m);
        logic [2:0] s;
        s = (m == 2'b00) ? 3'h2 : 3'h1;
        return d ? p - s : p + s;
    endfunction
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk(input logic s);
        apb(0, PHASE_OFFSET, '0);
        `CHK(rd[2:0], ph)
        `CHK(sleep_state, s)
        `CHK(phase_drive, s ? 4'h0 : exc(ph))
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK(hoe, 1'b0)
        apb(0, 8'h14, '0);
        `CHK(se, 1'b1)
        apb(0, IRQ_MASK_OFFSET, '0);
        `CHK(rd, 32'h0)
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            v = rnd();
            ctl.step(v[0], v[2:1]);
            ph = nxt(ph, v[0], v[2:1]);
            chk(0);
        end
        $display("step test done");
        apb(1, IRQ_MASK_OFFSET, 32'h1);
        ctl.disables(1, 0);
        `CHK(irq, 1'b1)
        ctl.step(0, 2'b01);
        ph = nxt(ph, 0, 2'b01);
        chk(1);
        apb(1, IRQ_STATUS_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        ctl.disables(0, 0);
        chk(0);
        $display("reference disable test done");
        ctl.pulse(0);
        `CHK(foe, 1'b0)
        ctl.disables(0, 1);
        `CHK(foe, 1'b1)
        ctl.step(1, 2'b00);
        chk(1);
        ctl.disables(0, 0);
        ctl.pulse(3);
        ph = 3'h0;
        chk(0);
        $display("hold sleep test done");
        apb(1, IRQ_STATUS_OFFSET, 32'hF);
        apb(1, IRQ_MASK_OFFSET, 32'hC);
        ctl.pulse(0);
        apb(0, STATUS_OFFSET, '0);
        `CHK(rd[ST_FAULT_BIT], 1'b1)
        `CHK(irq, 1'b1)
        apb(1, CTRL_OFFSET, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK(foe, 1'b1)
        apb(1, IRQ_STATUS_OFFSET, 32'hF);
        ctl.early(1'b0, 2'b01);
        ph = nxt(ph, 0, 2'b01);
        chk(0);
        apb(0, IRQ_STATUS_OFFSET, '0);
        `CHK(rd[EV_EARLY_STEP_BIT], 1'b1)
        repeat (24) @(posedge pclk);
        apb(0, STATUS_OFFSET, '0);
        `CHK(rd[ST_WAKE_OK_BIT], 1'b1)
        `CHK(rd[ST_OUT_EN_BIT], 1'b1)
        $display("fault and wake test done");
        test_done();
    end
endmodule
bind stepper_output_disable_control stepper_disable_properties chk_i (.pclk, .presetn,
    .pins, .phase_drive, .sleep_state, .home_monitor_o, .home_monitor_oe_n,
    .fault_flag_o, .fault_flag_oe_n);
`default_nettype wire
